// ==== verilog/pwrmc_ctrl.sv ====
// power mode, brownout and clock output controller with avalon-mm register slave
// Overview of operation
// - clock output only allowed with rc oscillator or external clock source
// - enabled clock output runs whenever oscillator runs, idle included
// - clock output is cpu clock divided by six
// - level select bit 1 picks 2.5 V threshold, 0 picks 3.8 V
// - auxiliary control bit 6 set disables brownout detection
// - power-up detection sets power-on flag until software clears it
// - idle bit enters idle; enabled interrupt or reset ends it, clears bit
// - power-down bit stops oscillator; bit cleared when power down ends
// - power down exits on reset or enabled higher-priority wake interrupt
// - watchdog keeps running in power down and may reset processor
// - brownout reset action resets device when supply below threshold
// - brownout interrupt action wakes from power down below threshold
// - wake restarts oscillator, waits 1024 crystal or 256 rc/ext clocks
// - brownout, watchdog and comparator stay active in power down
// - power control reset value 30h power-on, 20h brownout, else 00h
// - bit 7 doubles uart baud rate in serial modes 1 to 3
//
// Added by the designer: the Avalon-MM slave port.
`include "pwrmc_defs.svh"

module pwrmc_ctrl
  import pwrmc_pkg::*;
(
  input wire logic clock_i, // cpu clock
  input wire logic srst_i, // generic synchronous reset
  input wire logic por_i, // power-on detect level
  input wire logic [1:0] osc_sel_i, // configured oscillator type
  input wire logic brownout_level_select_i, // 1: 2.5 V, 0: 3.8 V
  input wire logic brownout_reset_en_i, // brownout action is reset
  input wire logic vdd_below_2v5_i, // comparator: supply below 2.5 V
  input wire logic vdd_below_3v8_i, // comparator: supply below 3.8 V
  input wire logic wdt_overflow_i, // watchdog overflow pulse
  input wire logic wake_irq_i, // enabled wake interrupt above current priority
  input wire logic idle_irq_i, // any enabled interrupt
  input wire logic brownout_irq_en_i, // brownout interrupt enabled
  input wire logic [1:0] serial_mode_i, // current uart mode
  input wire logic framing_error_i, // uart framing error flag
  input wire logic [7:0] avs_address_i, // avalon address
  input wire logic avs_read_i, // avalon read
  input wire logic avs_write_i, // avalon write
  input wire logic [7:0] avs_writedata_i, // avalon write data
  output logic [7:0] avs_readdata_o, // avalon read data
  output logic avs_waitrequest_o, // avalon wait
  output logic clock_out_pin_o, // divided clock output
  output logic clock_out_pin_oe_o, // clock output driver enable
  output logic osc_run_o, // main oscillator running
  output logic cpu_hold_o, // execution held off
  output logic idle_o, // idle mode active
  output logic sys_reset_o, // device reset request
  output logic baud_double_o, // uart baud doubling active
  output logic serial_bit7_o, // value shown at serial control bit 7
  output logic irq_o // interrupt level
);
  logic [7:0] pctl_reg;
  logic [7:0] pctl_next;
  logic [7:0] aux_reg;
  logic [7:0] p2mode_reg;
  logic serial_mode_bit_reg;
  logic [2:0] istat_reg;
  logic [2:0] istat_next;
  logic [2:0] imask_reg;

  pwrmc_state_type state_reg;
  pwrmc_state_type state_next;
  logic [10:0] wait_reg;
  logic [10:0] wait_next;
  logic [2:0] div_reg;
  logic por_seen_reg;

  logic ack_reg;
  logic [7:0] rdata_reg;
  logic clk_out_reg;
  logic clk_oe_reg;
  logic reset_reg;

  logic osc_reg;
  logic hold_reg;
  logic idle_reg;
  logic baud_reg;
  logic sb7_reg;
  logic irq_reg;

  function automatic logic osc_allows_clkout(input logic [1:0] sel);
    osc_allows_clkout = (sel == PWRMC_OSC_RC) || (sel == PWRMC_OSC_EXT);
  endfunction

  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] off);
    addr_hit = addr == off;
  endfunction

  function automatic logic [10:0] count_down(input logic [10:0] v);
    count_down = v - 11'h001;
  endfunction

  // one wait state; a write lands on the edge where waitrequest is seen low
  wire access_w = (avs_read_i | avs_write_i) & ~ack_reg;
  wire wr_w = avs_write_i & ack_reg;
  wire hit_pctl = addr_hit(avs_address_i, `PWRMC_OFF_PCTL);
  wire hit_aux = addr_hit(avs_address_i, `PWRMC_OFF_AUX);
  wire hit_p2 = addr_hit(avs_address_i, `PWRMC_OFF_P2MODE);
  wire hit_sctl = addr_hit(avs_address_i, `PWRMC_OFF_SCTL);
  wire hit_ist = addr_hit(avs_address_i, `PWRMC_OFF_IRQ_STAT);
  wire hit_imk = addr_hit(avs_address_i, `PWRMC_OFF_IRQ_MASK);
  wire hit_st = addr_hit(avs_address_i, `PWRMC_OFF_STATE);

  wire bo_disable = aux_reg[`PWRMC_BIT_BOD];
  wire bo_below = brownout_level_select_i ? vdd_below_2v5_i : vdd_below_3v8_i;
  // detector stays live in every power state
  wire bo_event = bo_below & ~bo_disable;
  wire bo_reset = bo_event & brownout_reset_en_i;
  wire bo_irq = bo_event & ~brownout_reset_en_i & brownout_irq_en_i;
  wire wdt_reset = wdt_overflow_i;

  // pin driven only by a source that may feed it, and never while stopped
  wire osc_on = state_reg != PWRMC_PDOWN;
  wire clkout_allowed = osc_allows_clkout(osc_sel_i);
  wire clkout_en = p2mode_reg[`PWRMC_BIT_CLKEN] & clkout_allowed & osc_on;

  wire [10:0] wake_wait = (osc_sel_i == PWRMC_OSC_XTAL) ? `PWRMC_WAIT_XTAL : `PWRMC_WAIT_RC;
  wire wake_pd = wake_irq_i | bo_irq;
  wire pctl_wr = wr_w & hit_pctl;
  wire [7:0] pctl_wdata = avs_writedata_i;

  // state machine: wake requests only count while in power down
  always_comb begin
    state_next = state_reg;
    wait_next = wait_reg;
    case (state_reg)
      PWRMC_RUN: begin
        if (pctl_reg[`PWRMC_BIT_PD]) begin
          state_next = PWRMC_PDOWN;
        end else if (pctl_reg[`PWRMC_BIT_IDL]) begin
          state_next = PWRMC_IDLE;
        end
      end
      PWRMC_IDLE: begin
        if (idle_irq_i) begin
          state_next = PWRMC_RUN;
        end
      end
      PWRMC_PDOWN: begin
        if (wake_pd) begin
          state_next = PWRMC_WAKE;
          wait_next = count_down(wake_wait);
        end
      end
      PWRMC_WAKE: begin
        if (wait_reg == 11'h000) begin
          state_next = PWRMC_RUN;
        end else begin
          wait_next = count_down(wait_reg);
        end
      end
      default: state_next = PWRMC_RUN;
    endcase
  end

  // software write first, then hardware sets win over clears
  always_comb begin
    pctl_next = pctl_reg;
    if (pctl_wr) begin
      pctl_next = pctl_wdata;
    end
    if (state_reg == PWRMC_IDLE && idle_irq_i) begin
      pctl_next[`PWRMC_BIT_IDL] = 1'b0;
    end
    if (state_reg == PWRMC_WAKE && wait_reg == 11'h000) begin
      pctl_next[`PWRMC_BIT_PD] = 1'b0;
    end
    if (bo_irq) begin
      pctl_next[`PWRMC_BIT_BOF] = 1'b1;
    end
  end

  always_comb begin
    istat_next = istat_reg;
    if (wr_w & hit_ist) begin
      istat_next = istat_reg & ~avs_writedata_i[2:0];
    end
    istat_next = istat_next | {wake_pd & (state_reg == PWRMC_PDOWN), bo_irq, por_i};
  end

  wire [7:0] sctl_view = {serial_bit7_o, 7'h00};
  wire [7:0] rd_mux = hit_pctl ? pctl_reg :
                      hit_aux ? aux_reg :
                      hit_p2 ? p2mode_reg :
                      hit_sctl ? sctl_view :
                      hit_ist ? {5'h00, istat_reg} :
                      hit_imk ? {5'h00, imask_reg} :
                      hit_st ? {4'h0, cpu_hold_o, osc_on, state_reg} : 8'h00;

  // power-on detect level captured each clock; feeds the device reset request one cycle late
  always_ff @(posedge clock_i) begin
    por_seen_reg <= por_i;
  end

  always_ff @(posedge clock_i) begin
    if (por_i) begin
      pctl_reg <= `PWRMC_RST_POWERON;
    end else if (bo_reset) begin
      pctl_reg <= `PWRMC_RST_BROWNOUT;
    end else if (srst_i | wdt_reset) begin
      pctl_reg <= `PWRMC_RST_OTHER;
    end else begin
      pctl_reg <= pctl_next;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i | por_i | bo_reset | wdt_reset) begin
      state_reg <= PWRMC_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i | por_i | bo_reset | wdt_reset) begin
      wait_reg <= 11'h000;
    end else begin
      wait_reg <= wait_next;
    end
  end

  // power-on event kept through reset, else the detect level is lost at release
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      istat_reg <= {2'b00, por_i};
    end else begin
      istat_reg <= istat_next;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      aux_reg <= 8'h00;
    end else if (wr_w & hit_aux) begin
      aux_reg <= avs_writedata_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      p2mode_reg <= 8'h00;
    end else if (wr_w & hit_p2) begin
      p2mode_reg <= avs_writedata_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      serial_mode_bit_reg <= 1'b0;
    end else if (wr_w & hit_sctl & ~pctl_reg[`PWRMC_BIT_SB7SEL]) begin
      serial_mode_bit_reg <= avs_writedata_i[7];
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      imask_reg <= 3'h0;
    end else if (wr_w & hit_imk) begin
      imask_reg <= avs_writedata_i[2:0];
    end
  end

  // divider stops with the oscillator; output high for 3, low for 3 cycles
  always_ff @(posedge clock_i) begin
    if (srst_i | ~clkout_en) begin
      div_reg <= 3'h0;
      clk_out_reg <= 1'b0;
    end else if (div_reg == `PWRMC_CLKDIV - 3'h1) begin
      div_reg <= 3'h0;
      clk_out_reg <= 1'b1;
    end else begin
      div_reg <= div_reg + 3'h1;
      if (div_reg == (`PWRMC_CLKDIV >> 1) - 3'h1) begin
        clk_out_reg <= 1'b0;
      end
    end
  end

  // bus answer after one wait state; read data registered from the decode
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= access_w;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rd_mux;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      clk_oe_reg <= 1'b0;
    end else begin
      clk_oe_reg <= clkout_en;
    end
  end

  // power-on seen one cycle late so the reset pulse outlasts the detect level
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      reset_reg <= 1'b0;
    end else begin
      reset_reg <= bo_reset | wdt_reset | por_seen_reg;
    end
  end

  assign avs_readdata_o = rdata_reg;
  assign avs_waitrequest_o = ~ack_reg;
  assign clock_out_pin_o = clk_out_reg;
  assign clock_out_pin_oe_o = clk_oe_reg;
  assign sys_reset_o = reset_reg;

  // mode outputs follow the next state so they line up with the state register
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      osc_reg <= 1'b1;
    end else begin
      osc_reg <= state_next != PWRMC_PDOWN;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      hold_reg <= 1'b0;
    end else begin
      hold_reg <= state_next != PWRMC_RUN;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      idle_reg <= 1'b0;
    end else begin
      idle_reg <= state_next == PWRMC_IDLE;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      baud_reg <= 1'b0;
    end else begin
      baud_reg <= pctl_next[`PWRMC_BIT_BAUD2] & (serial_mode_i != 2'b00);
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      sb7_reg <= 1'b0;
    end else begin
      sb7_reg <= pctl_next[`PWRMC_BIT_SB7SEL] ? framing_error_i : serial_mode_bit_reg;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(istat_next & imask_reg);
    end
  end

  assign osc_run_o = osc_reg;
  assign cpu_hold_o = hold_reg;
  assign idle_o = idle_reg;
  assign baud_double_o = baud_reg;
  assign serial_bit7_o = sb7_reg;
  assign irq_o = irq_reg;
endmodule // pwrmc_ctrl

// ==== common/pwrmc_defs.svh ====
// offsets, field positions, reset values and timing counts of the power controller
`ifndef PWRMC_DEFS_SVH
`define PWRMC_DEFS_SVH
`define PWRMC_ADDR_W 8
`define PWRMC_OFF_PCTL 8'h87
`define PWRMC_OFF_AUX 8'ha2
`define PWRMC_OFF_P2MODE 8'ha4
`define PWRMC_OFF_SCTL 8'h98
`define PWRMC_OFF_IRQ_STAT 8'hc0
`define PWRMC_OFF_IRQ_MASK 8'hc1
`define PWRMC_OFF_STATE 8'hc2
`define PWRMC_BIT_BAUD2 7
`define PWRMC_BIT_SB7SEL 6
`define PWRMC_BIT_BOF 5
`define PWRMC_BIT_POF 4
`define PWRMC_BIT_GF1 3
`define PWRMC_BIT_GF0 2
`define PWRMC_BIT_PD 1
`define PWRMC_BIT_IDL 0
`define PWRMC_BIT_BOD 6
`define PWRMC_BIT_CLKEN 6
`define PWRMC_RST_POWERON 8'h30
`define PWRMC_RST_BROWNOUT 8'h20
`define PWRMC_RST_OTHER 8'h00
`define PWRMC_CLKDIV 3'h6
`define PWRMC_WAIT_XTAL 11'h400
`define PWRMC_WAIT_RC 11'h100
`endif

// ==== common/pwrmc_pkg.sv ====
// types of the power controller
package pwrmc_pkg;
  typedef enum logic [1:0] {
    PWRMC_RUN = 2'b00,
    PWRMC_IDLE = 2'b01,
    PWRMC_PDOWN = 2'b10,
    PWRMC_WAKE = 2'b11
  } pwrmc_state_type;
  typedef enum logic [1:0] {
    PWRMC_OSC_XTAL = 2'b00,
    PWRMC_OSC_RC = 2'b01,
    PWRMC_OSC_EXT = 2'b10
  } pwrmc_osc_type;
endpackage

// ==== verification/pwrmc_ctrl_chk.sv ====
// port assertions of the power controller
`include "pwrmc_defs.svh"
module pwrmc_ctrl_chk (
  input logic clock_i, // clock
  input logic srst_i, // reset
  input logic [1:0] osc_sel_i, // osc type
  input logic wdt_overflow_i, // watchdog
  input logic wake_irq_i, // wake irq
  input logic idle_irq_i, // idle irq
  input logic [1:0] serial_mode_i, // uart mode
  input logic [7:0] avs_address_i, // address
  input logic avs_write_i, // write
  input logic [7:0] avs_writedata_i, // data
  input logic avs_waitrequest_o, // wait
  input logic clock_out_pin_o, // clock out
  input logic clock_out_pin_oe_o, // clock out enable
  input logic osc_run_o, // osc on
  input logic cpu_hold_o, // hold
  input logic idle_o, // idle
  input logic sys_reset_o, // reset out
  input logic baud_double_o // baud x2
);
  logic [11:0] wake_cnt_reg;
  logic [11:0] wake_cnt_next;
  logic [11:0] lim;
  logic pctl_wr;
  assign pctl_wr = avs_write_i && !avs_waitrequest_o && avs_address_i == `PWRMC_OFF_PCTL;
  assign lim = osc_sel_i == 2'b00 ? {1'b0, `PWRMC_WAIT_XTAL} : {1'b0, `PWRMC_WAIT_RC};
  assign wake_cnt_next = (osc_run_o && cpu_hold_o && !idle_o) ? wake_cnt_reg + 12'h001 : 12'h000;
  always_ff @(posedge clock_i) wake_cnt_reg <= srst_i ? 12'h000 : wake_cnt_next;
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  sequence hi3_lo1;
    clock_out_pin_o [*3] ##1 !clock_out_pin_o;
  endsequence
  clk_gate_a: assert property (osc_sel_i == 2'b00 [*2] |-> !clock_out_pin_oe_o)
    else $error("clock output driven with crystal source");
  clk_div_a: assert property (disable iff (srst_i || !osc_run_o || !clock_out_pin_oe_o)
    $rose(clock_out_pin_o) |-> hi3_lo1) else $error("clock output not three high three low");
  wdt_rst_a: assert property (wdt_overflow_i |-> ##[1:2] sys_reset_o)
    else $error("watchdog overflow gave no reset");
  idle_exit_a: assert property (idle_o && idle_irq_i |-> ##[1:2] !idle_o)
    else $error("idle not left on interrupt");
  pd_stop_a: assert property (pctl_wr && avs_writedata_i[`PWRMC_BIT_PD] && !wake_irq_i
    |-> ##[1:3] !osc_run_o) else $error("oscillator kept running in power down");
  pd_wake_a: assert property (!osc_run_o && wake_irq_i |-> ##[1:3] osc_run_o)
    else $error("oscillator not restarted on wake");
  wake_wait_a: assert property ($fell(cpu_hold_o) && wake_cnt_reg != 12'h000
    |-> wake_cnt_reg + 12'h004 >= lim && wake_cnt_reg <= lim + 12'h002)
    else $error("stability wait of wrong length");
  baud_mode_a: assert property (serial_mode_i == 2'b00 [*2] |-> !baud_double_o)
    else $error("baud doubled in mode zero");
endmodule // pwrmc_ctrl_chk
bind pwrmc_ctrl pwrmc_ctrl_chk i_pwrmc_ctrl_chk (.clock_i, .srst_i, .osc_sel_i, .wdt_overflow_i,
  .wake_irq_i, .idle_irq_i, .serial_mode_i, .avs_address_i, .avs_write_i, .avs_writedata_i,
  .avs_waitrequest_o, .clock_out_pin_o, .clock_out_pin_oe_o, .osc_run_o, .cpu_hold_o, .idle_o,
  .sys_reset_o, .baud_double_o);

// ==== verification/tb.sv ====
// self-checking bench of the power controller
`include "pwrmc_defs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0, srst_i = 1'b1, por_i = 1'b1, brownout_level_select_i = 1'b0;
  logic brownout_reset_en_i = 1'b0, vdd_below_2v5_i = 1'b0, vdd_below_3v8_i = 1'b0;
  logic wdt_overflow_i = 1'b0, wake_irq_i = 1'b0, idle_irq_i = 1'b0, brownout_irq_en_i = 1'b1;
  logic framing_error_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [1:0] osc_sel_i = 2'b01, serial_mode_i = 2'b00;
  logic [7:0] avs_address_i = 8'h00, avs_writedata_i = 8'h00, avs_readdata_o, q;
  logic avs_waitrequest_o, clock_out_pin_o, clock_out_pin_oe_o, osc_run_o, cpu_hold_o, idle_o;
  logic sys_reset_o, baud_double_o, serial_bit7_o, irq_o;
  int error_cnt = 0, num_checks = 0;
  always #4 clock_i = ~clock_i;
  pwrmc_ctrl i_pwrmc_ctrl (.clock_i, .srst_i, .por_i, .osc_sel_i, .brownout_level_select_i,
    .brownout_reset_en_i, .vdd_below_2v5_i, .vdd_below_3v8_i, .wdt_overflow_i, .wake_irq_i,
    .idle_irq_i, .brownout_irq_en_i, .serial_mode_i, .framing_error_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
    .clock_out_pin_o, .clock_out_pin_oe_o, .osc_run_o, .cpu_hold_o, .idle_o, .sys_reset_o,
    .baud_double_o, .serial_bit7_o, .irq_o);
  task chk(input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task finish_test;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task wt(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  // request held until waitrequest is seen low at an edge
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do @(posedge clock_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task t_regs;
    bus(0, `PWRMC_OFF_PCTL, 8'h00);
    chk(q, `PWRMC_RST_POWERON);
    bus(1, `PWRMC_OFF_IRQ_MASK, 8'h01);
    wt(2);
    chk(8'(irq_o), 8'h01);
    bus(1, `PWRMC_OFF_IRQ_STAT, 8'h01);
    wt(2);
    chk(8'(irq_o), 8'h00);
    bus(1, `PWRMC_OFF_PCTL, 8'h0c);
    bus(0, `PWRMC_OFF_PCTL, 8'h00);
    chk(q, 8'h0c);
    bus(0, 8'h10, 8'h00);
    chk(q, 8'h00);
  endtask
  task t_uart(input logic [7:0] v);
    serial_mode_i <= 2'b01;
    framing_error_i <= 1'b1;
    bus(1, `PWRMC_OFF_PCTL, v);
    wt(2);
    chk(8'(baud_double_o), 8'(v[7]));
    chk(8'(serial_bit7_o), 8'(v[6]));
  endtask
  task t_clk;
    int n;
    logic p;
    n = 0;
    p = 1'b1;
    bus(1, `PWRMC_OFF_P2MODE, 8'h40);
    wt(8);
    repeat (60) begin
      @(posedge clock_i);
      if (clock_out_pin_o === 1'b1 && p === 1'b0) n++;
      p = clock_out_pin_o;
    end
    chk(8'(n), 8'h0a);
    osc_sel_i <= 2'b00;
    wt(3);
    chk(8'(clock_out_pin_oe_o), 8'h00);
    osc_sel_i <= 2'b10;
    wt(3);
    chk(8'(clock_out_pin_oe_o), 8'h01);
    osc_sel_i <= 2'b01;
  endtask
  task t_idle;
    bus(1, `PWRMC_OFF_PCTL, 8'h01);
    wt(3);
    chk(8'(idle_o), 8'h01);
    chk(8'(clock_out_pin_oe_o), 8'h01);
    idle_irq_i <= 1'b1;
    wt(3);
    chk(8'(idle_o), 8'h00);
    idle_irq_i <= 1'b0;
    bus(0, `PWRMC_OFF_PCTL, 8'h00);
    chk(q, 8'h00);
  endtask
  // wake by enabled interrupt or by brownout interrupt
  task t_pd(input logic [1:0] s, input int lim, input logic bo);
    int n;
    n = 0;
    osc_sel_i <= s;
    bus(1, `PWRMC_OFF_PCTL, 8'h02);
    wt(3);
    chk(8'(osc_run_o), 8'h00);
    if (bo) vdd_below_3v8_i <= 1'b1;
    else wake_irq_i <= 1'b1;
    wt(4);
    chk(8'(osc_run_o), 8'h01);
    vdd_below_3v8_i <= 1'b0;
    wake_irq_i <= 1'b0;
    while (cpu_hold_o !== 1'b0 && n < 2000) begin
      @(posedge clock_i);
      n++;
    end
    chk(8'(n >= lim - 8 && n <= lim + 4), 8'h01);
    bus(0, `PWRMC_OFF_PCTL, 8'h00);
    chk(q, {2'b00, bo, 5'h00});
  endtask
  task t_bo;
    brownout_irq_en_i <= 1'b0;
    brownout_reset_en_i <= 1'b1;
    bus(1, `PWRMC_OFF_AUX, 8'h40);
    vdd_below_3v8_i <= 1'b1;
    wt(4);
    chk(8'(sys_reset_o), 8'h00);
    brownout_level_select_i <= 1'b1;
    bus(1, `PWRMC_OFF_AUX, 8'h00);
    wt(4);
    chk(8'(sys_reset_o), 8'h00);
    vdd_below_2v5_i <= 1'b1;
    wt(4);
    chk(8'(sys_reset_o), 8'h01);
    vdd_below_2v5_i <= 1'b0;
    vdd_below_3v8_i <= 1'b0;
    wt(4);
    bus(0, `PWRMC_OFF_PCTL, 8'h00);
    chk(q, `PWRMC_RST_BROWNOUT);
    wdt_overflow_i <= 1'b1;
    wt(1);
    wdt_overflow_i <= 1'b0;
    wt(4);
    bus(0, `PWRMC_OFF_PCTL, 8'h00);
    chk(q, `PWRMC_RST_OTHER);
  endtask
  initial begin
    wt(8);
    srst_i <= 1'b0;
    por_i <= 1'b0;
    t_regs;
    t_uart(8'hc0);
    t_uart(8'h00);
    serial_mode_i <= 2'b00;
    t_clk;
    t_idle;
    t_pd(2'b01, 256, 1'b0);
    t_pd(2'b00, 1024, 1'b0);
    t_pd(2'b01, 256, 1'b1);
    t_bo;
    finish_test;
  end
  // hang guard well beyond the few thousand cycles needed
  initial begin
    #100us;
    error_cnt++;
    finish_test;
  end
endmodule // tb
